//--- logic/dcc_top.sv
/*
 * Control and status logic around two analog comparators, APB slave.
 * Assumes analog comparators outside deliver raw results, and that the
 * analog front end obeys the mode, input switch and power-down outputs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_cfg.svh"

module dcc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] cmp_raw,
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe,
    output logic [2:0] comparator_mode,
    output logic input_switch_select,
    output logic vref_to_positive,
    output logic comparators_on,
    output logic irq,
    output logic wake
);
    logic [3:0] ctrl_q;
    logic [1:0] latch_q;
    logic chg_q;
    logic cie_q;
    logic gie_q;
    logic peripheral_irq_enable_q;
    logic sleep_q;
    logic [4:0] dir_q;
    logic [4:0] port_q;
    logic [1:0] res;
    logic [4:0] pin_sync;
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_s3_q;

    // Index decode shared by read and write paths
    function automatic logic hit(input logic [31:0] a, input logic [7:0] i);
        hit = (a[31:10] == 22'h0) && (a[9:2] == i) && (a[1:0] == 2'h0);
    endfunction : hit

    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire h_ctrl = hit(paddr, `DCC_IDX_CTRL);
    wire h_flag = hit(paddr, `DCC_IDX_FLAG);
    wire h_ien = hit(paddr, `DCC_IDX_IEN);
    wire h_int = hit(paddr, `DCC_IDX_INTERRUPT_CONTROL_REG);
    wire h_dir = hit(paddr, `DCC_IDX_DIR);
    wire h_port = hit(paddr, `DCC_IDX_PORT);
    wire mapped = h_ctrl | h_flag | h_ien | h_int | h_dir | h_port;
    wire dcc_pkg::dcc_mode_t mode = dcc_pkg::dcc_mode_t'(ctrl_q[2:0]);

    // Always ready; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;

    // Results are the synchronised comparator outputs, forced low when off
    dcc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(cmp_raw),
        .sync_out(res)
    );

    // Pin inputs pass three flops, change counts when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            pin_s3_q <= 5'h00;
            pin_sync <= 5'h00;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_sync <= (pin_s2_q & pin_s3_q)
                | (pin_sync & (pin_s2_q | pin_s3_q));
        end
    end

    // Analog front-end steering
    assign comparator_mode = ctrl_q[2:0];
    assign input_switch_select = ctrl_q[`DCC_BIT_CIS];
    assign vref_to_positive = (mode == dcc_pkg::DCC_MODE_VREF);
    // Off in mode 111 and in reset mode; presetn low also holds 000
    assign comparators_on = (mode != dcc_pkg::DCC_MODE_OFF)
        && (mode != dcc_pkg::DCC_MODE_RESET);

    // Result bits, high when positive input above negative
    wire [1:0] res_eff = comparators_on ? res : 2'h0;

    // Analog pin mask per mode: RA0..RA3 analog except off/pin modes
    wire [4:0] analog_mask =
        (mode == dcc_pkg::DCC_MODE_OFF) ? 5'h00 :
        (mode == dcc_pkg::DCC_MODE_PINOUT) ? 5'h07 :
        (mode == dcc_pkg::DCC_MODE_VREF) ? 5'h0f : 5'h0f;

    // Mode 110: pins three and four carry raw unsynchronised results
    wire pin_mux = (mode == dcc_pkg::DCC_MODE_PINOUT);
    always_comb begin
        pin_out = port_q;
        if (pin_mux) begin
            pin_out[`DCC_PIN_C1] = cmp_raw[0];
            pin_out[`DCC_PIN_C2] = cmp_raw[1];
        end
    end
    // Direction bit still gates the driver; analog pins never driven
    assign pin_oe = ~dir_q & ~analog_mask;

    // Mismatch between present results and latched copy
    wire mismatch = (res_eff != latch_q);
    wire ctrl_acc = acc & h_ctrl;
    wire flag_wr = wr & h_flag;

    // Latch results on any control access, otherwise hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_q <= 2'h0;
        end else if (ctrl_acc) begin
            latch_q <= res_eff;
        end
    end

    // Flag: mismatch sets, set beats software clear; a change arriving
    // in the control access cycle is latched silently and lost
    wire chg_set = mismatch & ~ctrl_acc;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_q <= 1'b0;
        end else if (chg_set) begin
            chg_q <= 1'b1;
        end else if (flag_wr) begin
            chg_q <= pwdata[`DCC_BIT_CHG];
        end
    end

    // Control register: results bits not stored, writes ignored there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `DCC_RST_CTRL;
        end else if (wr & h_ctrl) begin
            ctrl_q <= pwdata[3:0];
        end
    end

    // Enables, sleep control, direction and port latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cie_q <= 1'b0;
            gie_q <= 1'b0;
            peripheral_irq_enable_q <= 1'b0;
            sleep_q <= 1'b0;
            dir_q <= `DCC_RST_DIR;
            port_q <= `DCC_RST_PORT;
        end else begin
            if (wr & h_ien) begin
                cie_q <= pwdata[`DCC_BIT_CHG];
                sleep_q <= pwdata[`DCC_BIT_SLEEP];
            end else if (wake) begin
                sleep_q <= 1'b0;
            end
            if (wr & h_int) begin
                gie_q <= pwdata[`DCC_BIT_GIE];
                peripheral_irq_enable_q <= pwdata[`DCC_BIT_PERIPHERAL_IRQ_ENABLE];
            end
            if (wr & h_dir) begin
                dir_q <= pwdata[4:0];
            end
            if (wr & h_port) begin
                port_q <= pwdata[4:0];
            end
        end
    end

    // Interrupt needs all three enables; wake needs only cie_q, not the other two
    assign irq = chg_q & cie_q & peripheral_irq_enable_q & gie_q;
    assign wake = sleep_q & chg_q & cie_q;

    // Read mux; analog pins read zero
    wire [4:0] port_rd = pin_sync & ~analog_mask;
    wire [7:0] ctrl_rd = {res_eff[1], res_eff[0], 2'h0, ctrl_q};
    wire [7:0] rd_byte =
        h_ctrl ? ctrl_rd :
        h_flag ? {1'b0, chg_q, 6'h00} :
        h_ien ? {1'b0, cie_q, 5'h00, sleep_q} :
        h_int ? {gie_q, peripheral_irq_enable_q, 6'h00} :
        h_dir ? {3'h0, dir_q} :
        h_port ? {3'h0, port_rd} : 8'h00;

    // Read data loaded at the setup edge, so it stands at the access edge
    // where the master takes it with zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Checks
    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        irq |-> (chg_q && cie_q && peripheral_irq_enable_q && gie_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

    property p_mismatch_sets;
        @(posedge pclk) disable iff (!presetn)
        (mismatch && !ctrl_acc) |=> chg_q;
    endproperty
    a_mismatch_sets: assert property (p_mismatch_sets) else $error("flag not set");

    property p_mismatch_holds;
        @(posedge pclk) disable iff (!presetn)
        (mismatch && !ctrl_acc && flag_wr) |=> chg_q;
    endproperty
    a_mismatch_holds: assert property (p_mismatch_holds) else $error("clear won");

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        ctrl_acc |=> (latch_q == $past(res_eff));
    endproperty
    a_latch: assert property (p_latch) else $error("no latch on access");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (flag_wr && !mismatch) |=> (chg_q == $past(pwdata[6]));
    endproperty
    a_clear: assert property (p_clear) else $error("flag write lost");

    property p_vref;
        @(posedge pclk) disable iff (!presetn)
        vref_to_positive |-> (comparator_mode == 3'h2);
    endproperty
    a_vref: assert property (p_vref) else $error("vref route wrong");

    property p_pin_oe;
        @(posedge pclk) disable iff (!presetn)
        (pin_mux && dir_q[3]) |-> !pin_oe[3];
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("driver ignores dir");

    property p_off;
        @(posedge pclk) disable iff (!presetn)
        (comparator_mode == 3'h7) |-> (!comparators_on && res_eff == 2'h0);
    endproperty
    a_off: assert property (p_off) else $error("off mode active");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        (chg_q && cie_q && peripheral_irq_enable_q && gie_q) |-> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing");

    property p_pin_raw;
        @(posedge pclk) disable iff (!presetn)
        pin_mux |-> ((pin_out[`DCC_PIN_C1] == cmp_raw[0])
            && (pin_out[`DCC_PIN_C2] == cmp_raw[1]));
    endproperty
    a_pin_raw: assert property (p_pin_raw) else $error("pin not raw");

    // Read data of the port must hide every analog pin
    property p_port_zero;
        @(posedge pclk) disable iff (!presetn)
        (rd_setup && h_port) |=> ((prdata[4:0] & $past(analog_mask)) == 5'h00);
    endproperty
    a_port_zero: assert property (p_port_zero) else $error("analog pin read");
endmodule : dcc_top
`default_nettype wire

//--- include/dcc_cfg.svh
/*
 * Constants for the dual comparator control block: register indices,
 * field positions, reset values and result pin positions.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

// Register indices; byte address is four times the index
`define DCC_IDX_FLAG 8'h0c
`define DCC_IDX_CTRL 8'h1f
`define DCC_IDX_IEN 8'h8c
`define DCC_IDX_INTERRUPT_CONTROL_REG 8'h0b
`define DCC_IDX_DIR 8'h85
`define DCC_IDX_PORT 8'h05
// Field positions
`define DCC_BIT_C2 7
`define DCC_BIT_C1 6
`define DCC_BIT_CIS 3
`define DCC_BIT_CHG 6
`define DCC_BIT_GIE 7
`define DCC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define DCC_BIT_SLEEP 0
// Reset values
`define DCC_RST_CTRL 4'h0
`define DCC_RST_DIR 5'h1f
`define DCC_RST_PORT 5'h00
// Port pins carrying comparator results
`define DCC_PIN_C1 3
`define DCC_PIN_C2 4

`endif

//--- include/dcc_pkg.sv
/*
 * Types shared by the dual comparator control block.
 * Assumes nothing of its surroundings.
 */
package dcc_pkg;
    // Comparator modes, encoded as the three mode bits
    typedef enum logic [2:0] {
        DCC_MODE_RESET = 3'h0,
        DCC_MODE_ONE = 3'h1,
        DCC_MODE_VREF = 3'h2,
        DCC_MODE_THREE = 3'h3,
        DCC_MODE_FOUR = 3'h4,
        DCC_MODE_FIVE = 3'h5,
        DCC_MODE_PINOUT = 3'h6,
        DCC_MODE_OFF = 3'h7
    } dcc_mode_t;
endpackage : dcc_pkg

//--- logic/dcc_sync.sv
/*
 * Three-stage synchroniser for the two comparator results.
 * Assumes asynchronous analog comparator outputs on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module dcc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;

    // A change counts only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
            s3_q <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
        end
    end
endmodule : dcc_sync
`default_nettype wire

//--- tb/dcc_analog_model.sv
/*
 * Behavioural pair of analog comparators for the control block.
 * Assumes the bench drives input levels as unsigned codes.
 */
`timescale 1ns/10ps
`default_nettype none
module dcc_analog_model (
    input wire logic vref_to_positive,
    input wire logic comparators_on,
    input wire logic [7:0] vref_lvl,
    input wire logic [7:0] pos_lvl,
    input wire logic [7:0] neg1_lvl,
    input wire logic [7:0] neg2_lvl,
    output logic [1:0] cmp_raw
);
    logic [7:0] pos_sel;
    // Internal reference replaces the pin on both positive inputs
    assign pos_sel = vref_to_positive ? vref_lvl : pos_lvl;
    // Powered-down comparators hold a low result, never a stale one
    assign cmp_raw[0] = comparators_on & (pos_sel > neg1_lvl);
    assign cmp_raw[1] = comparators_on & (pos_sel > neg2_lvl);
endmodule : dcc_analog_model
`default_nettype wire

//--- tb/tb_dual_comparator_control.sv
/*
 * Self-checking bench for the dual comparator control block.
 * Assumes the analog pair model and the shared constants header.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_cfg.svh"
module tb_dual_comparator_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rdat;
    logic [1:0] cmp_raw;
    logic [4:0] pin_in, pin_out, pin_oe;
    logic [2:0] comparator_mode;
    logic input_switch_select, vref_to_positive, comparators_on, irq, wake;
    logic [7:0] vref_lvl, pos_lvl, neg1_lvl, neg2_lvl;
    int fail_count, check_count;

    dcc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cmp_raw, .pin_in, .pin_out, .pin_oe,
        .comparator_mode, .input_switch_select, .vref_to_positive,
        .comparators_on, .irq, .wake);
    dcc_analog_model model (.vref_to_positive, .comparators_on, .vref_lvl,
        .pos_lvl, .neg1_lvl, .neg2_lvl, .cmp_raw);

    // Free-running bus clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Setup then access phase; request held until pready at an edge
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        // A wait that runs out counts as a mismatch
        if (n >= 50) begin
            fail_count++;
        end
        err = pslverr;
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the access edge settle before outputs are compared
        #1;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [31:0] e, string nm);
        apb(1'b0, idx, 32'h0);
        chk(nm, rdat, e);
    endtask : rd

    // Fixed settle span covers sync stages plus change detection
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt

    task automatic t_reset;
        rd(`DCC_IDX_CTRL, 32'h0, "ctrl");
        rd(`DCC_IDX_FLAG, 32'h0, "flag");
        rd(`DCC_IDX_IEN, 32'h0, "ien");
        rd(`DCC_IDX_DIR, 32'h1f, "dir");
        chk("mode", 32'(comparator_mode), 32'h0);
        chk("on", 32'(comparators_on), 32'h0);
        chk("oe", 32'(pin_oe), 32'h0);
        chk("pins rst", 32'(pin_out), 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_flag;
        logic [7:0] prev;
        wr(`DCC_IDX_CTRL, 32'h2);
        wt(12);
        rd(`DCC_IDX_CTRL, 32'h42, "ctrl vref");
        prev = rdat[7:0];
        chk("vref", 32'(vref_to_positive), 32'h1);
        wr(`DCC_IDX_FLAG, 32'h0);
        rd(`DCC_IDX_FLAG, 32'h0, "flag clr");
        @(posedge pclk);
        neg2_lvl <= 8'h32;
        wt(12);
        rd(`DCC_IDX_FLAG, 32'h40, "flag set");
        wr(`DCC_IDX_FLAG, 32'h0);
        rd(`DCC_IDX_FLAG, 32'h40, "flag held");
        rd(`DCC_IDX_CTRL, 32'hc2, "ctrl both");
        chk("changed", 32'(prev ^ rdat[7:0]), 32'h80);
        wr(`DCC_IDX_FLAG, 32'h0);
        rd(`DCC_IDX_FLAG, 32'h0, "flag end");
        wr(`DCC_IDX_FLAG, 32'h40);
        rd(`DCC_IDX_FLAG, 32'h40, "flag soft");
        $display("test flag done");
    endtask : t_flag

    task automatic t_irq;
        wr(`DCC_IDX_INTERRUPT_CONTROL_REG, 32'h40);
        wr(`DCC_IDX_IEN, 32'h40);
        chk("irq off", 32'(irq), 32'h0);
        wr(`DCC_IDX_INTERRUPT_CONTROL_REG, 32'hc0);
        chk("irq on", 32'(irq), 32'h1);
        wr(`DCC_IDX_IEN, 32'h41);
        chk("wake", 32'(wake), 32'h1);
        wt(2);
        rd(`DCC_IDX_CTRL, 32'hc2, "ctrl wake");
        // Interrupts masked before mode changes
        wr(`DCC_IDX_INTERRUPT_CONTROL_REG, 32'h0);
        wr(`DCC_IDX_IEN, 32'h0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_pins;
        wr(`DCC_IDX_CTRL, 32'h6);
        @(posedge pclk);
        pos_lvl <= 8'h96;
        wr(`DCC_IDX_DIR, 32'h7);
        chk("oe out", 32'(pin_oe), 32'h18);
        chk("pins", 32'(pin_out[4:3]), 32'h3);
        @(posedge pclk);
        neg1_lvl <= 8'hc8;
        #1 chk("pins raw", 32'(pin_out[4:3]), 32'h2);
        wr(`DCC_IDX_DIR, 32'h1f);
        chk("oe in", 32'(pin_oe), 32'h0);
        rd(`DCC_IDX_PORT, 32'h18, "port 110");
        $display("test pins done");
    endtask : t_pins

    task automatic t_off;
        wr(`DCC_IDX_CTRL, 32'hff);
        chk("on off", 32'(comparators_on), 32'h0);
        chk("cis", 32'(input_switch_select), 32'h1);
        chk("mode off", 32'(comparator_mode), 32'h7);
        rd(`DCC_IDX_CTRL, 32'hf, "ctrl ro");
        rd(`DCC_IDX_PORT, 32'h1f, "port 111");
        wr(`DCC_IDX_PORT, 32'h1b);
        chk("latch out", 32'(pin_out), 32'h1b);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        chk("unmapped data", rdat, 32'h0);
        $display("test off done");
    endtask : t_off

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // Hang guard, well beyond the whole sequence
    initial begin
        repeat (3000) @(posedge pclk);
        fail_count++;
        end_sim;
    end

    // Main sequence
    initial begin
        fail_count = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pin_in = 5'h1f;
        vref_lvl = 8'hc8;
        pos_lvl = 8'h0;
        neg1_lvl = 8'h64;
        neg2_lvl = 8'hfa;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_flag;
        t_irq;
        t_pins;
        t_off;
        end_sim;
    end
endmodule : tb_dual_comparator_control
`default_nettype wire
